// File: tpc_port_config.sv
// Purpose: Per-port TDM configuration register and its pin-side effects
// Assumes: Line clocks far slower than clk; sampled as plain inputs
// Notes:   One instance per port; PORT_INDEX sets the decoded address
// Operation
// RQ1 - Six-bit unframed rate field, 1=64k, 2=128k, feeds timestamp only
// RQ2 - Rate bit picks 1.544 or 2.048 MHz for framed E1/T1 ports
// RQ3 - Software never sets E1 type with the 1.544 MHz rate
// RQ4 - Defect modifier field goes into control word M field
// RQ5 - Receive enable low discards outgoing traffic, data and signaling high
// RQ6 - Serial type drives clear-to-send pin from its bit, reset one
// RQ7 - Serial carrier enable gates carrier pin driven from carrier bit
// RQ8 - Loss bit sets control word L bit for this port
// RQ9 - Five-bit field picks jitter buffer for clock recovery
// RQ10 - SF to ESF CAS bundle inserts field as C and D bits
// RQ11 - Slot bank change takes effect at next sync input assertion
// RQ12 - Transmit enable low discards incoming traffic toward the network
// RQ13 - Two-clock mode: receive sample bit picks receive clock edge
// RQ14 - One-clock mode: transmit sample bit picks sample and update edges
// RQ15 - Software writes zero to the two top bits
// RQ16 - Two-clock bit: 0 one transmit clock, 1 separate receive clock
// RQ17 - Interface type: 00 serial, 01 E1, 10 T1, 11 reserved
// RQ18 - Framing: unframed, frame sync, multiframe or SF, ESF
// RQ19 - One independent register instance per port
// RQ20 - Field changes reach port logic within a few cycles
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module tpc_port_config #(
    parameter int PORT_INDEX = 1,
    parameter int NUM_PORTS  = 8
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        line_transmit_clock,
    input  wire logic        line_receive_clock,
    input  wire logic        line_receive_data,
    input  wire logic        line_receive_sync,
    input  wire logic        line_receive_signaling_or_request,
    input  wire logic        line_transmit_sync,
    input  wire logic        line_multiframe_or_carrier_in,
    output logic             line_multiframe_or_carrier_out,
    output logic             line_multiframe_or_carrier_oe,
    output logic             line_transmit_data,
    output logic             line_transmit_signaling_or_clear,
    input  wire logic        tx_bit,
    input  wire logic        tx_sig,
    output logic             tx_take,
    output logic             rx_valid,
    output logic             rx_bit,
    output logic             rx_frame_sync,
    output logic             rx_sig,
    output logic             tx_frame_sync,
    output logic             tx_multiframe,
    input  wire logic        peer_superframe,
    output logic       [1:0] cw_m_bits,
    output logic             cw_l_bit,
    output logic       [4:0] recovery_jitter_buffer_index,
    output logic       [1:0] substituted_signaling_bits,
    output logic             cas_substitute_en,
    output logic             active_slot_map_bank,
    output logic       [5:0] unframed_rate,
    output logic             line_rate_2048,
    output logic       [1:0] interface_type,
    output logic       [1:0] framing_type
);
    // Assertions share the system clock and its reset
    default clocking cb_sys @(posedge clk); endclocking
    default disable iff (!resetn);
    // ==========================================================
    // Elaboration checks
    if (PORT_INDEX < 1 || PORT_INDEX > NUM_PORTS || NUM_PORTS > 8)
        $error("tpc_port_config: port index out of range");

    localparam logic [7:0] CFG_ADDR = 8'(tpc_pkg::CFG_BASE_OFFSET
        + 8'(PORT_INDEX) * tpc_pkg::CFG_PORT_STRIDE);
    localparam logic [7:0] STAT_ADDR = 8'(tpc_pkg::STATUS_BASE
        + 8'(PORT_INDEX) * tpc_pkg::CFG_PORT_STRIDE);

    // Picks one of two line-clock edges by a config bit
    function automatic logic pick_edge(input logic rise, input logic fall,
                                       input logic use_rise);
        pick_edge = use_rise ? rise : fall;
    endfunction : pick_edge

    // ==========================================================
    // Configuration register
    logic [31:0] cfg_ff;

    // Top two bits never stored, so they read as zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_ff <= tpc_pkg::CFG_RESET_VALUE;
        end else if (ce && reg_wr && reg_addr == CFG_ADDR) begin
            cfg_ff <= reg_wdata & tpc_pkg::CFG_WRITE_MASK; // [RQ15] [RQ19]
        end
    end

    // Field views
    logic       rx_en_c;
    logic       tx_en_c;
    logic       two_clk_c;
    logic       rx_samp_c;
    logic       tx_samp_c;
    logic [1:0] type_c;
    logic [1:0] frame_c;
    logic       serial_c;
    assign rx_en_c   = cfg_ff[tpc_pkg::RX_EN_BIT];
    assign tx_en_c   = cfg_ff[tpc_pkg::TX_EN_BIT];
    assign two_clk_c = cfg_ff[tpc_pkg::TWO_CLK_BIT];
    assign rx_samp_c = cfg_ff[tpc_pkg::RX_SAMPLE_BIT];
    assign tx_samp_c = cfg_ff[tpc_pkg::TX_SAMPLE_BIT];
    assign type_c    = cfg_ff[tpc_pkg::IF_TYPE_LSB +: 2];
    assign frame_c   = cfg_ff[tpc_pkg::FRAMING_LSB +: 2];
    assign serial_c  = (type_c == tpc_pkg::IF_SERIAL); // [RQ17]

    // ==========================================================
    // Pin synchronisers: three stages, change taken when 2nd and 3rd agree
    logic [tpc_pkg::NUM_SYNC-1:0] pin_c;
    logic [tpc_pkg::NUM_SYNC-1:0] s1_ff;
    logic [tpc_pkg::NUM_SYNC-1:0] s2_ff;
    logic [tpc_pkg::NUM_SYNC-1:0] s3_ff;
    logic [tpc_pkg::NUM_SYNC-1:0] flt_ff;
    logic [tpc_pkg::NUM_SYNC-1:0] nxt_flt;
    assign pin_c = {line_multiframe_or_carrier_in, line_transmit_sync,
                    line_receive_signaling_or_request, line_receive_sync,
                    line_receive_data, line_receive_clock,
                    line_transmit_clock};
    assign nxt_flt = (s2_ff & s3_ff) | (flt_ff & (s2_ff ^ s3_ff));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            flt_ff <= '0;
        end else if (ce) begin
            s1_ff  <= pin_c;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            flt_ff <= nxt_flt;
        end
    end

    // Edges of the filtered line clocks
    logic t_rise;
    logic t_fall;
    logic r_rise;
    logic r_fall;
    logic tx_in_edge;
    logic tx_out_edge;
    logic rx_in_edge;
    assign t_rise = nxt_flt[tpc_pkg::S_TCLK] & ~flt_ff[tpc_pkg::S_TCLK];
    assign t_fall = ~nxt_flt[tpc_pkg::S_TCLK] & flt_ff[tpc_pkg::S_TCLK];
    assign r_rise = nxt_flt[tpc_pkg::S_RCLK] & ~flt_ff[tpc_pkg::S_RCLK];
    assign r_fall = ~nxt_flt[tpc_pkg::S_RCLK] & flt_ff[tpc_pkg::S_RCLK];
    // Sample bit 0: inputs on falling, outputs on rising; 1 the reverse
    assign tx_in_edge  = pick_edge(t_rise, t_fall, tx_samp_c); // [RQ14]
    assign tx_out_edge = pick_edge(t_fall, t_rise, tx_samp_c); // [RQ14]
    // Receive side follows its own clock only in two-clock mode
    assign rx_in_edge = two_clk_c
        ? pick_edge(r_rise, r_fall, rx_samp_c)                 // [RQ13]
        : tx_in_edge;                                          // [RQ16]

    // ==========================================================
    // Receive pins toward the network side
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_valid      <= 1'b0;
            rx_bit        <= 1'b0;
            rx_frame_sync <= 1'b0;
            rx_sig        <= 1'b0;
        end else if (ce) begin
            // Disabled port drops bits here rather than downstream
            rx_valid <= rx_in_edge & tx_en_c;                    // [RQ12]
            if (rx_in_edge) begin
                rx_bit        <= nxt_flt[tpc_pkg::S_RXD];
                rx_frame_sync <= nxt_flt[tpc_pkg::S_RXSYNC];
                rx_sig        <= nxt_flt[tpc_pkg::S_RXSIG];
            end
        end
    end

    // Transmit-side inputs, sampled on the transmit clock
    logic tx_sync_rise;
    assign tx_sync_rise = tx_in_edge & nxt_flt[tpc_pkg::S_TXSYNC]
                          & ~tx_frame_sync;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_frame_sync <= 1'b0;
            tx_multiframe <= 1'b0;
        end else if (ce && tx_in_edge) begin
            tx_frame_sync <= nxt_flt[tpc_pkg::S_TXSYNC];
            // Carrier pin is an input only when not serial
            tx_multiframe <= serial_c ? 1'b0 : nxt_flt[tpc_pkg::S_TXMF];
        end
    end

    // ==========================================================
    // Transmit pins from the network side
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_transmit_data <= 1'b1;
            tx_take            <= 1'b0;
        end else if (ce) begin
            tx_take <= tx_out_edge & rx_en_c;
            if (tx_out_edge) begin
                line_transmit_data <= rx_en_c ? tx_bit : 1'b1; // [RQ5]
            end
        end
    end

    // Signaling pin doubles as clear-to-send on serial ports
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_transmit_signaling_or_clear <= 1'b1;
        end else if (ce) begin
            if (serial_c) begin
                line_transmit_signaling_or_clear <=
                    cfg_ff[tpc_pkg::CTS_BIT];                    // [RQ6]
            end else if (tx_out_edge) begin
                line_transmit_signaling_or_clear <=
                    rx_en_c ? tx_sig : 1'b1;                     // [RQ5]
            end
        end
    end

    // Carrier-detect drive; released whenever the port is not serial
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_multiframe_or_carrier_out <= 1'b0;
            line_multiframe_or_carrier_oe  <= 1'b0;
        end else if (ce) begin
            line_multiframe_or_carrier_oe  <=
                serial_c & cfg_ff[tpc_pkg::CARRIER_DETECT_OUTPUT_ENABLE_BIT];          // [RQ7]
            line_multiframe_or_carrier_out <= cfg_ff[tpc_pkg::CD_BIT];
        end
    end

    // ==========================================================
    // Slot map bank, swapped only at a transmit sync assertion
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            active_slot_map_bank <= 1'b0;
        end else if (ce && tx_sync_rise) begin
            active_slot_map_bank <= cfg_ff[tpc_pkg::BANK_BIT];   // [RQ11]
        end
    end

    // ==========================================================
    // Field copies toward packet and clock-recovery logic
    logic framed_c;
    logic rate_applies_c;
    assign framed_c       = (frame_c != tpc_pkg::FR_UNFRAMED);   // [RQ18]
    assign rate_applies_c = framed_c
        && (type_c == tpc_pkg::IF_E1 || type_c == tpc_pkg::IF_T1);

    // One cycle behind the register, so always prompt
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cw_m_bits                    <= 2'h0;
            cw_l_bit                     <= 1'b0;
            recovery_jitter_buffer_index <= 5'h00;
            substituted_signaling_bits   <= 2'h0;
            cas_substitute_en            <= 1'b0;
            unframed_rate                <= 6'h00;
            line_rate_2048               <= 1'b0;
            interface_type               <= tpc_pkg::IF_SERIAL;
            framing_type                 <= tpc_pkg::FR_UNFRAMED;
        end else if (ce) begin                                  // [RQ20]
            cw_m_bits <= cfg_ff[tpc_pkg::DEFECT_M_LSB +: 2];     // [RQ4]
            cw_l_bit  <= cfg_ff[tpc_pkg::LOSS_BIT];              // [RQ8]
            recovery_jitter_buffer_index <=
                cfg_ff[tpc_pkg::JB_IDX_LSB +: tpc_pkg::JB_IDX_W]; // [RQ9]
            substituted_signaling_bits <=
                cfg_ff[tpc_pkg::SUBST_LSB +: 2];                 // [RQ10]
            cas_substitute_en <= peer_superframe
                && type_c == tpc_pkg::IF_T1
                && frame_c == tpc_pkg::FR_ESF;                   // [RQ10]
            unframed_rate <=                                     // [RQ1]
                cfg_ff[tpc_pkg::UNFR_RATE_LSB +: tpc_pkg::UNFR_RATE_W];
            // Outside framed E1/T1 the rate follows the type itself
            line_rate_2048 <= rate_applies_c
                ? cfg_ff[tpc_pkg::PCM_RATE_BIT]
                : (type_c == tpc_pkg::IF_E1);                    // [RQ2]
            interface_type <= type_c;
            framing_type   <= frame_c;
        end
    end

    // ==========================================================
    // Register read port, data one cycle after the strobe
    logic [31:0] status_c;
    assign status_c = {26'h0,
        (type_c == tpc_pkg::IF_E1) && rate_applies_c
            && !cfg_ff[tpc_pkg::PCM_RATE_BIT],                   // [RQ3]
        (type_c == tpc_pkg::IF_RESERVED),
        flt_ff[tpc_pkg::S_RCLK],
        flt_ff[tpc_pkg::S_TCLK],
        active_slot_map_bank != cfg_ff[tpc_pkg::BANK_BIT],
        active_slot_map_bank};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (ce) begin
            if (!reg_rd) begin
                reg_rdata <= 32'h0000_0000;
            end else if (reg_addr == CFG_ADDR) begin
                reg_rdata <= cfg_ff;
            end else if (reg_addr == STAT_ADDR) begin
                reg_rdata <= status_c;
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Checks
    // Serial ports keep clear-to-send on the signaling pin even when disabled
    chk_tx_held_high: assert property (                          // [RQ5]
        ce && tx_out_edge && !rx_en_c |=> line_transmit_data
            && (line_transmit_signaling_or_clear || $past(serial_c)))
        else $error("transmit pins not held high while disabled");
    chk_cts_follows: assert property (                           // [RQ6]
        ce && serial_c |=> line_transmit_signaling_or_clear
            == $past(cfg_ff[tpc_pkg::CTS_BIT]))
        else $error("clear-to-send pin differs from its bit");
    chk_cd_drive: assert property (                              // [RQ7]
        ce |=> line_multiframe_or_carrier_oe
            == $past(serial_c && cfg_ff[tpc_pkg::CARRIER_DETECT_OUTPUT_ENABLE_BIT]))
        else $error("carrier output enable wrong");
    chk_bank_waits: assert property (                            // [RQ11]
        !tx_sync_rise |=> $stable(active_slot_map_bank))
        else $error("slot bank changed without sync");
    chk_bank_takes: assert property (                            // [RQ11]
        ce && tx_sync_rise |=> active_slot_map_bank
            == $past(cfg_ff[tpc_pkg::BANK_BIT]))
        else $error("slot bank missed the sync");
    chk_rx_discard: assert property (                            // [RQ12]
        rx_valid && $past(ce) |-> $past(tx_en_c) && $past(rx_in_edge))
        else $error("receive bit passed while disabled");
    chk_m_field: assert property (                               // [RQ4]
        ce |=> cw_m_bits == $past(cfg_ff[tpc_pkg::DEFECT_M_LSB +: 2]))
        else $error("control word M bits stale");
    chk_loss_bit: assert property (                              // [RQ8]
        ce ##1 ce |=> cw_l_bit == $past(cfg_ff[tpc_pkg::LOSS_BIT]))
        else $error("control word L bit stale");
    chk_one_clock: assert property (                             // [RQ16]
        ce && !two_clk_c && tx_en_c && t_fall && !tx_samp_c |=> rx_valid)
        else $error("one-clock mode missed transmit clock edge");
    chk_rx_edge: assert property (                               // [RQ13]
        ce && two_clk_c && tx_en_c && r_fall && !rx_samp_c |=> rx_valid)
        else $error("receive edge selection wrong");
    chk_tx_edges: assert property (                              // [RQ14]
        ce && rx_en_c && t_rise && !tx_samp_c |=> tx_take)
        else $error("transmit edge selection wrong");
    chk_rate_sel: assert property (                              // [RQ2]
        ce && !framed_c |=> line_rate_2048 == $past(type_c == tpc_pkg::IF_E1))
        else $error("line rate ignored framing");

    cov_bank_swap: cover property (@(posedge clk) disable iff (!resetn)
        tx_sync_rise && active_slot_map_bank != cfg_ff[tpc_pkg::BANK_BIT]);
    cov_rx_bit: cover property (@(posedge clk) disable iff (!resetn)
        rx_valid && two_clk_c);
    cov_cd_on: cover property (@(posedge clk) disable iff (!resetn)
        line_multiframe_or_carrier_oe);
endmodule : tpc_port_config
`default_nettype wire

// File: tpc_pkg.sv
// Purpose: Constants for the per-port TDM configuration register block
// Assumes: 32-bit register port, one block instance per TDM port
// Notes:   Field positions are given as low bit; width only for the unframed rate and jitter buffer fields
`default_nettype none
package tpc_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0]  CFG_BASE_OFFSET   = 8'h08;
    localparam logic [7:0]  CFG_PORT_STRIDE   = 8'h04;
    localparam logic [7:0]  STATUS_BASE       = 8'h40;
    localparam logic [31:0] CFG_RESET_VALUE   = 32'h000a_0051;
    localparam logic [31:0] CFG_WRITE_MASK    = 32'h3fff_fffc | 32'h3;
    // ==========================================================
    // Field positions
    localparam int UNFR_RATE_LSB = 24;
    localparam int UNFR_RATE_W   = 6;
    localparam int PCM_RATE_BIT  = 23;
    localparam int DEFECT_M_LSB  = 21;
    localparam int RX_EN_BIT     = 20;
    localparam int CTS_BIT       = 19;
    localparam int CARRIER_DETECT_OUTPUT_ENABLE_BIT     = 18;
    localparam int CD_BIT        = 17;
    localparam int LOSS_BIT      = 16;
    localparam int JB_IDX_LSB    = 11;
    localparam int JB_IDX_W      = 5;
    localparam int SUBST_LSB     = 9;
    localparam int BANK_BIT      = 8;
    localparam int TX_EN_BIT     = 7;
    localparam int RX_SAMPLE_BIT = 6;
    localparam int TX_SAMPLE_BIT = 5;
    localparam int TWO_CLK_BIT   = 4;
    localparam int FRAMING_LSB   = 2;
    localparam int IF_TYPE_LSB   = 0;
    // ==========================================================
    // Encodings
    localparam logic [1:0] IF_SERIAL   = 2'h0;
    localparam logic [1:0] IF_E1       = 2'h1;
    localparam logic [1:0] IF_T1       = 2'h2;
    localparam logic [1:0] IF_RESERVED = 2'h3;
    localparam logic [1:0] FR_UNFRAMED = 2'h0;
    localparam logic [1:0] FR_FRAME    = 2'h1;
    localparam logic [1:0] FR_MULTI    = 2'h2;
    localparam logic [1:0] FR_ESF      = 2'h3;
    // ==========================================================
    // Synchronised pin slots
    localparam int NUM_SYNC  = 7;
    localparam int S_TCLK    = 0;
    localparam int S_RCLK    = 1;
    localparam int S_RXD     = 2;
    localparam int S_RXSYNC  = 3;
    localparam int S_RXSIG   = 4;
    localparam int S_TXSYNC  = 5;
    localparam int S_TXMF    = 6;
    localparam logic [2:0] SYNC_RESET = 3'h0;
endpackage : tpc_pkg
`default_nettype wire

// File: tpc_line_model.sv
// Purpose: Far-side line equipment model for one TDM port
// Assumes: Free-running transmit clock, receive clock gated by rclk_run
// Notes:   Behavioural; line levels are chosen by the bench
`timescale 1ns/100ps
`default_nettype none
module tpc_line_model (
    input  wire logic rclk_run,
    input  wire logic rx_level,
    input  wire logic sync_level,
    input  wire logic mf_out,
    input  wire logic mf_oe,
    output logic      tclk,
    output logic      rclk,
    output logic      rxd,
    output logic      sync,
    output wire logic mf_wire
);
    logic last_lvl;
    // ==========================================================
    // Line clocks, 800 ns period, phase unrelated to clk
    initial begin
        {tclk, rclk, rxd, sync, last_lvl} = 5'h0;
        #37;
        forever begin
            #400 tclk = ~tclk;
            if (rclk_run) rclk = ~rclk;
        end
    end
    // Data move on falling clock, the same edge the block samples on with the bench's sample bits of 0
    always @(negedge tclk) begin
        rxd  <= rx_level;
        sync <= sync_level;
    end
    // Released pin shows inverse of last level: no pull on it
    always @(mf_out or mf_oe) if (mf_oe) last_lvl = mf_out;
    assign mf_wire = mf_oe ? mf_out : ~last_lvl;
endmodule : tpc_line_model
`default_nettype wire

// File: tb.sv
// Purpose: Register and line-side checks of one port configuration block
// Assumes: Block instance for port 2, clock enable held high
// Notes:   Counts taken at falling clk, clear of launch edges
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [7:0] CFG = 8'h10; // Port 2 sits at 0x08 + 4*2
    logic        clk, resetn, reg_wr, reg_rd, tx_bit, peer_sf;
    logic        rclk_run, rx_level, sync_level, tclk, rclk, rxd, sync;
    logic        mf_wire, mf_out, mf_oe, txd, tsig, tx_take, rx_valid;
    logic        rx_bit, cw_l, cas_en, bank, rate_2048;
    logic        rx_fs, rx_sg, tx_fs, tx_mf;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [1:0]  cw_m, subst, if_type, fr_type;
    logic [4:0]  jb;
    logic [5:0]  ufr;
    int          n_fail, checks_done, nv, nt;
    // ==========================================================
    // Block and far side
    tpc_port_config #(.PORT_INDEX(2)) i_tpc_port_config (.clk(clk),
        .resetn(resetn), .ce(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .line_transmit_clock(tclk),
        .line_receive_clock(rclk), .line_receive_data(rxd),
        .line_receive_sync(sync), .line_receive_signaling_or_request(rxd),
        .line_transmit_sync(sync), .line_multiframe_or_carrier_in(mf_wire),
        .line_multiframe_or_carrier_out(mf_out),
        .line_multiframe_or_carrier_oe(mf_oe), .line_transmit_data(txd),
        .line_transmit_signaling_or_clear(tsig), .tx_bit(tx_bit),
        .tx_sig(tx_bit), .tx_take(tx_take), .rx_valid(rx_valid),
        .rx_bit(rx_bit), .rx_frame_sync(rx_fs), .rx_sig(rx_sg),
        .tx_frame_sync(tx_fs), .tx_multiframe(tx_mf),
        .peer_superframe(peer_sf), .cw_m_bits(cw_m),
        .cw_l_bit(cw_l), .recovery_jitter_buffer_index(jb),
        .substituted_signaling_bits(subst), .cas_substitute_en(cas_en),
        .active_slot_map_bank(bank), .unframed_rate(ufr),
        .line_rate_2048(rate_2048), .interface_type(if_type),
        .framing_type(fr_type));
    tpc_line_model i_tpc_line_model (.rclk_run(rclk_run),
        .rx_level(rx_level), .sync_level(sync_level), .mf_out(mf_out),
        .mf_oe(mf_oe), .tclk(tclk), .rclk(rclk), .rxd(rxd), .sync(sync),
        .mf_wire(mf_wire));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    // Settling gap first, so pulses of the old setup are not counted
    task automatic run_line(input int n);
        repeat (8) @(posedge clk);
        nv = 0;
        nt = 0;
        repeat (n) begin
            @(negedge clk);
            nv += (rx_valid === 1'b1);
            nt += (tx_take === 1'b1);
        end
    endtask : run_line
    task automatic close_out;
        if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out
    // ==========================================================
    // Clock and main sequence
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {resetn, reg_wr, reg_rd, tx_bit, peer_sf} = 5'h0;
        {rclk_run, sync_level, reg_addr, reg_wdata} = 42'h0;
        rx_level = 1'b1;
        repeat (8) @(posedge clk);
        chk(txd, 1'b1);
        chk(tsig, 1'b1);
        resetn <= 1'b1;
        rd(CFG, 32'h000a_0051);
        wr(CFG, 32'hffff_ffff);
        rd(CFG, 32'h3fff_ffff);
        chk(cw_m, 2'h3);
        chk(cw_l, 1'b1);
        chk(jb, 5'h1f);
        chk(subst, 2'h3);
        chk(ufr, 6'h3f);
        // Port 1's address: ignored here and reads zero
        wr(8'h0c, 32'h0);
        rd(8'h0c, 32'h0);
        rd(CFG, 32'h3fff_ffff);
        // Serial port: field copies and modem-control pins
        wr(CFG, 32'h0244_2a00);
        rd(CFG, 32'h0244_2a00);
        chk(ufr, 6'h02);
        chk(cw_m, 2'h2);
        chk(cw_l, 1'b0);
        chk(jb, 5'h05);
        chk(subst, 2'h1);
        chk(tsig, 1'b0);
        chk({mf_oe, mf_out}, 2'h2);
        wr(CFG, 32'h000e_0000);
        rd(CFG, 32'h000e_0000);
        chk(tsig, 1'b1);
        chk(mf_wire, 1'b1);
        wr(CFG, 32'h000a_0000);
        rd(CFG, 32'h000a_0000);
        chk(mf_oe, 1'b0);
        // Framed T1 rates and CAS substitution
        wr(CFG, 32'h0000_0006);
        rd(CFG, 32'h0000_0006);
        chk({rate_2048, if_type, fr_type}, 5'h09);
        @(posedge clk) peer_sf <= 1'b1;
        wr(CFG, 32'h0000_000e);
        rd(CFG, 32'h0000_000e);
        chk({cas_en, fr_type}, 3'h7);
        // Framed E1 at 2.048: both enables low drop traffic, both high pass it
        wr(CFG, 32'h0088_0005);
        run_line(64);
        chk(nv, 0);
        chk(nt, 0);
        chk(txd, 1'b1);
        wr(CFG, 32'h0098_0085);
        run_line(64);
        chk({nv > 0, nt > 0}, 2'h3);
        chk({rx_bit, txd, tsig, rate_2048}, 4'h9);
        // Two-clock mode: receive side follows only the receive clock
        wr(CFG, 32'h0098_0095);
        run_line(64);
        chk(nv, 0);
        rclk_run <= 1'b1;
        run_line(64);
        chk(nv > 0, 1'b1);
        // Bank swap waits for the sync input
        wr(CFG, 32'h0000_0101);
        run_line(32);
        chk(bank, 1'b0);
        sync_level <= 1'b1;
        for (int i = 0; i < 200 && bank !== 1'b1; i++) @(negedge clk);
        chk(bank, 1'b1);
        // Syncs sampled on the same edge; released carrier pin reads low
        chk({rx_fs, rx_sg, tx_fs, tx_mf}, 4'he);
        close_out();
    end
endmodule : tb
`default_nettype wire
